/* File: nsl_cfg.svh */
// Purpose: timing and code constants of the LED sequencer
// Assumes: 50 MHz clock, millisecond timebase
// Notes:   LED times in milliseconds
`ifndef NSL_CFG_SVH
`define NSL_CFG_SVH

`define NSL_CLK_HZ         50000000
`define NSL_MS_PER_S       1000
`define NSL_MS_W           12

// green flash patterns, 1 Hz repetition
`define NSL_FLASH_HZ       1
`define NSL_FLASH_ON_MS    150
`define NSL_FLASH_GAP_MS   150
`define NSL_FLASH_STEP_MS  (`NSL_FLASH_ON_MS + `NSL_FLASH_GAP_MS)
`define NSL_FLASH_PER_MS   (`NSL_MS_PER_S / `NSL_FLASH_HZ)
`define NSL_FLASH_SINGLE   1
`define NSL_FLASH_DOUBLE   2
`define NSL_FLASH_TRIPLE   3

// even blink, 2.5 Hz given in tenths of hertz
`define NSL_BLINK_DHZ      25
`define NSL_BLINK_PER_MS   (`NSL_MS_PER_S * 10 / `NSL_BLINK_DHZ)
// flicker, 10 Hz
`define NSL_FLICK_HZ       10
`define NSL_FLICK_PER_MS   (`NSL_MS_PER_S / `NSL_FLICK_HZ)

// red system stop code
`define NSL_ERR_SHORT_MS   150
`define NSL_ERR_LONG_MS    600
`define NSL_ERR_GAP_MS     150
`define NSL_ERR_PAUSE_S    2
`define NSL_ERR_PAUSE_MS   (`NSL_ERR_PAUSE_S * `NSL_MS_PER_S)
`define NSL_ERR_PHASES     4
// first phase in the msb, a one means long
`define NSL_CODE_MEM       4'h1
`define NSL_CODE_HW        4'h9

`endif

/* File: nsl_pkg.sv */
// Purpose: shared types of the LED sequencer
// Assumes: nothing
// Notes:   structs carry event, fault and control groups
package nsl_pkg;

    typedef enum logic [2:0] {
        NS_NOT_ACTIVE, NS_BASIC_ETH, NS_PREOP1, NS_PREOP2,
        NS_READY, NS_OPER, NS_STOPPED
    } nsl_node_t;

    typedef enum logic [2:0] {
        PAT_OFF, PAT_ON, PAT_FLICKER, PAT_SINGLE,
        PAT_DOUBLE, PAT_TRIPLE, PAT_BLINK
    } nsl_pat_t;

    typedef struct packed {
        logic link_timeout; // no frame seen in the startup window
        logic frame_seen;   // protocol traffic detected
        logic soc_rx;       // start-of-cycle frame received
        logic cmd_ready;    // go to ready-to-operate
        logic cmd_oper;     // go to operational
        logic cmd_stop;     // go to stopped
        logic cmd_preop2;   // go to pre-operational 2
    } nsl_evt_t;

    typedef struct packed {
        logic mem_fault;    // memory fault detected
        logic hw_fault;     // general hardware fault detected
    } nsl_err_t;

    typedef struct packed {
        logic accept_cfg;   // configuration from the manager allowed
        logic cyclic_run;   // cyclic communication running
        logic async_run;    // asynchronous communication running
        logic eval_rx;      // received cyclic data is evaluated
        logic discard_pdo;  // received process data dropped
        logic pdo_mapped;   // transmit data laid out by mapping
        logic out_data;     // output data delivered
        logic in_data;      // input data provided
    } nsl_ctl_t;

endpackage

/* File: nsl_ms_tick.sv */
// Purpose: one-cycle millisecond enable
// Assumes: DIV is clock cycles per millisecond
// Notes:   tick is registered
`timescale 1ns/1ps
module nsl_ms_tick #(
    parameter int unsigned DIV = 50000
) (
    input  wire logic clk,   // system clock
    input  wire logic rst_n, // synchronous reset, low active
    output logic      tick   // one-cycle pulse per millisecond
);
    localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else if (cnt_reg >= LAST) begin
            cnt_reg <= '0;
            tick    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + W'(1);
            tick    <= 1'b0;
        end
    end
endmodule

/* File: nsl_err_code.sv */
// Purpose: four-phase red error code, pause after each
// Assumes: code stays stable while run is high
// Notes:   code msb is the first phase, one means long
`timescale 1ns/1ps
`include "nsl_cfg.svh"
module nsl_err_code (
    input  wire logic       clk,     // system clock
    input  wire logic       rst_n,   // synchronous reset, low active
    input  wire logic       ms_tick, // millisecond enable
    input  wire logic       run,     // error latched
    input  wire logic [3:0] code,    // phase lengths, msb first
    output logic            led      // red level request
);
    typedef enum logic [1:0] {ER_ON, ER_GAP, ER_PAUSE} nsl_er_t;
    localparam logic [1:0] LAST_IDX = 2'(`NSL_ERR_PHASES - 1);

    nsl_er_t               st_reg;
    logic [1:0]            idx_reg;
    logic [`NSL_MS_W-1:0]  cnt_reg;

    function automatic logic [`NSL_MS_W-1:0] on_len(input logic lng);
        return lng ? `NSL_MS_W'(`NSL_ERR_LONG_MS - 1)
                   : `NSL_MS_W'(`NSL_ERR_SHORT_MS - 1); // [RULE_13]
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg  <= ER_ON;
            idx_reg <= 2'h0;
            cnt_reg <= '0;
        end else if (!run) begin
            st_reg  <= ER_ON;
            idx_reg <= 2'h0;
            cnt_reg <= on_len(code[3]);
        end else if (ms_tick) begin
            if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - `NSL_MS_W'(1);
            end else begin
                case (st_reg)
                    ER_ON: begin
                        if (idx_reg == LAST_IDX) begin
                            st_reg  <= ER_PAUSE; // [RULE_14]
                            cnt_reg <= `NSL_MS_W'(`NSL_ERR_PAUSE_MS - 1);
                        end else begin
                            st_reg  <= ER_GAP; // [RULE_20]
                            cnt_reg <= `NSL_MS_W'(`NSL_ERR_GAP_MS - 1);
                        end
                    end
                    ER_GAP: begin
                        st_reg  <= ER_ON;
                        idx_reg <= idx_reg + 2'h1;
                        cnt_reg <= on_len(code[2'h2 - idx_reg]);
                    end
                    ER_PAUSE: begin
                        st_reg  <= ER_ON; // [RULE_14]
                        idx_reg <= 2'h0;
                        cnt_reg <= on_len(code[3]);
                    end
                    default: begin
                        st_reg <= ER_ON;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            led <= 1'b0;
        end else begin
            led <= run && (st_reg == ER_ON);
        end
    end
endmodule

/* File: nsl_status_led.sv */
// Purpose: node state tracking and status/error LED sequencing
// Assumes: events and faults are one-cycle synchronous pulses
// Notes:   green pattern changes at a repetition end
`timescale 1ns/1ps
`include "nsl_cfg.svh"

//////////////////////////////////////////////////////////////////////////

// Behaviour
// RULE_01 - pre-operational 2: green double flash, 1 Hz
// RULE_02 - ready-to-operate: green triple flash, 1 Hz
// RULE_03 - operational: green steady, mapped data evaluated
// RULE_04 - stopped: green even blink, 2.5 Hz
// RULE_05 - manager pre-op 2: cyclic on, no evaluation
// RULE_06 - node goes ready only on command
// RULE_07 - node red on when manager failed; code lights it only in pre-op 1, pre-op 2 and ready
// RULE_08 - manager ready: cyclic, async, drop data
// RULE_09 - node ready: mapped transmit, no evaluation
// RULE_10 - manager never enters stopped
// RULE_11 - node stopped: no output, no input
// RULE_12 - stopped entered and left only by command
// RULE_13 - stop error: four red phases, short/long
// RULE_14 - repeat code forever, two second pause
// RULE_15 - memory fault: short short short long
// RULE_16 - hardware fault: long short short long
// RULE_17 - pre-operational 1: green single flash, 1 Hz
// RULE_18 - node pre-op 1 leaves on start-of-cycle
// RULE_19 - basic ethernet: green flicker, 10 Hz
// RULE_20 - fixed gaps; pattern changes at repetition
// RULE_21 - latched stop error overrides all indications
module nsl_status_led #(
    parameter int unsigned TICK_DIV = `NSL_CLK_HZ / `NSL_MS_PER_S
) (
    input  wire logic               CLOCK,       // 50 MHz clock
    input  wire logic               RST_N,       // sync reset, low
    input  wire logic               ROLE_MN,     // 1: managing node
    input  wire nsl_pkg::nsl_evt_t  EVT,         // protocol events
    input  wire logic               MN_FAIL,     // manager lost
    input  wire nsl_pkg::nsl_err_t  ERR,         // fault pulses
    output nsl_pkg::nsl_node_t      NODE_STATE,  // current state
    output nsl_pkg::nsl_ctl_t       CTL,         // data path enables
    output logic                    ERR_LATCHED, // stop error held
    output logic                    LED_GREEN,   // status LED
    output logic                    LED_RED      // error LED
);
    import nsl_pkg::*;

    //////////////////////////////////////////////////////////////////////
    // declarations

    localparam int unsigned MS_W = `NSL_MS_W;

    logic                ms_tick;
    logic                mn_reg;
    nsl_node_t           state_reg;
    nsl_node_t           state_next;
    logic                err_reg;
    logic [3:0]          code_reg;
    nsl_pat_t            pat_reg;
    nsl_pat_t            pat_want;
    logic [MS_W-1:0]     cnt_reg;
    logic                green_lvl;
    logic                red_code;
    logic                red_fail;
    nsl_ctl_t            ctl_next;

    //////////////////////////////////////////////////////////////////////
    // millisecond timebase and error code engine

    nsl_ms_tick #(
        .DIV   (TICK_DIV)
    ) u_tick (
        .clk   (CLOCK),
        .rst_n (RST_N),
        .tick  (ms_tick)
    );

    nsl_err_code u_err (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .ms_tick (ms_tick),
        .run     (ERR_LATCHED), // code_reg settles first
        .code    (code_reg),
        .led     (red_code)
    );

    //////////////////////////////////////////////////////////////////////
    // role: sampled while inactive, then frozen
    // so a strap glitch cannot flip roles mid-run

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            mn_reg <= 1'b0;
        end else if (state_reg == NS_NOT_ACTIVE) begin
            mn_reg <= ROLE_MN;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // node state machine

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            NS_NOT_ACTIVE: begin
                // a manager that sees traffic is not started
                if (EVT.link_timeout) begin
                    state_next = mn_reg ? NS_PREOP1 : NS_BASIC_ETH;
                end else if (EVT.frame_seen && !mn_reg) begin
                    state_next = NS_PREOP1;
                end
            end
            NS_BASIC_ETH: begin
                // manager leaves only through reset
                if (EVT.frame_seen && !mn_reg) begin
                    state_next = NS_PREOP1;
                end
            end
            NS_PREOP1: begin
                if (!mn_reg && EVT.soc_rx) begin
                    state_next = NS_PREOP2; // [RULE_18]
                end else if (mn_reg && EVT.cmd_preop2) begin
                    state_next = NS_PREOP2;
                end
            end
            NS_PREOP2: begin
                if (!mn_reg && EVT.cmd_stop) begin
                    state_next = NS_STOPPED; // [RULE_12]
                end else if (EVT.cmd_ready) begin
                    state_next = NS_READY; // [RULE_06]
                end
            end
            NS_READY: begin
                if (!mn_reg && EVT.cmd_stop) begin
                    state_next = NS_STOPPED; // [RULE_12] [RULE_10]
                end else if (EVT.cmd_oper) begin
                    state_next = NS_OPER;
                end
            end
            NS_OPER: begin
                if (!mn_reg && EVT.cmd_stop) begin
                    state_next = NS_STOPPED; // [RULE_12] [RULE_10]
                end
            end
            NS_STOPPED: begin
                // only a command brings a controlled node back; a manager leaves at once
                if (mn_reg) begin
                    state_next = NS_PREOP2; // [RULE_10]
                end else if (EVT.cmd_preop2) begin
                    state_next = NS_PREOP2; // [RULE_12]
                end
            end
            default: begin
                state_next = NS_NOT_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state_reg <= NS_NOT_ACTIVE;
        end else begin
            state_reg <= state_next;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // data path enables per state and role

    always_comb begin
        ctl_next = '0;
        case (state_reg)
            NS_PREOP1: begin
                ctl_next.accept_cfg = !mn_reg;
            end
            NS_PREOP2: begin
                ctl_next.accept_cfg  = !mn_reg; // [RULE_06]
                ctl_next.cyclic_run  = mn_reg;  // [RULE_05]
                ctl_next.discard_pdo = mn_reg;  // [RULE_05]
            end
            NS_READY: begin
                ctl_next.cyclic_run  = 1'b1;    // [RULE_08]
                ctl_next.async_run   = 1'b1;    // [RULE_08]
                ctl_next.discard_pdo = mn_reg;  // [RULE_08]
                ctl_next.pdo_mapped  = !mn_reg; // [RULE_09]
                ctl_next.out_data    = !mn_reg; // [RULE_09]
            end
            NS_OPER: begin
                ctl_next.cyclic_run = 1'b1;     // [RULE_03]
                ctl_next.async_run  = 1'b1;
                ctl_next.eval_rx    = 1'b1;     // [RULE_03]
                ctl_next.pdo_mapped = 1'b1;     // [RULE_03]
                ctl_next.out_data   = 1'b1;
                ctl_next.in_data    = 1'b1;
            end
            NS_STOPPED: begin
                ctl_next.async_run = 1'b1;
                ctl_next.out_data  = 1'b0;      // [RULE_11]
                ctl_next.in_data   = 1'b0;      // [RULE_11]
            end
            default: begin
                ctl_next = '0;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////
    // system stop error latch, held until reset

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            err_reg  <= 1'b0;
            code_reg <= 4'h0;
        end else if (!err_reg) begin
            // hardware fault wins when both arrive together
            if (ERR.hw_fault) begin
                err_reg  <= 1'b1;
                code_reg <= `NSL_CODE_HW;  // [RULE_16]
            end else if (ERR.mem_fault) begin
                err_reg  <= 1'b1;
                code_reg <= `NSL_CODE_MEM; // [RULE_15]
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // green pattern selection

    always_comb begin
        case (state_reg)
            NS_BASIC_ETH: pat_want = PAT_FLICKER;  // [RULE_19]
            NS_PREOP1:    pat_want = PAT_SINGLE;   // [RULE_17]
            NS_PREOP2:    pat_want = PAT_DOUBLE;   // [RULE_01]
            NS_READY:     pat_want = PAT_TRIPLE;   // [RULE_02]
            NS_OPER:      pat_want = PAT_ON;       // [RULE_03]
            NS_STOPPED: begin
                pat_want = mn_reg ? PAT_OFF : PAT_BLINK; // [RULE_04]
            end
            default:      pat_want = PAT_OFF;
        endcase
    end

    // last millisecond of one repetition; steady levels reload each ms
    function automatic logic [MS_W-1:0] pat_last(input nsl_pat_t p);
        case (p)
            PAT_SINGLE, PAT_DOUBLE, PAT_TRIPLE: begin
                return MS_W'(`NSL_FLASH_PER_MS - 1);
            end
            PAT_BLINK:   return MS_W'(`NSL_BLINK_PER_MS - 1);
            PAT_FLICKER: return MS_W'(`NSL_FLICK_PER_MS - 1);
            default:     return '0;
        endcase
    endfunction

    // n flashes of fixed length with fixed gaps, then dark
    function automatic logic flash_hit(input logic [MS_W-1:0] c,
                                       input int unsigned     n);
        logic hit;
        hit = 1'b0;
        for (int unsigned k = 0; k < n; k++) begin
            if (c >= MS_W'(k * `NSL_FLASH_STEP_MS) &&
                c <  MS_W'(k * `NSL_FLASH_STEP_MS + `NSL_FLASH_ON_MS)) begin
                hit = 1'b1; // [RULE_20]
            end
        end
        return hit;
    endfunction

    //////////////////////////////////////////////////////////////////////
    // green repetition counter

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            pat_reg <= PAT_OFF;
            cnt_reg <= '0;
        end else if (ms_tick) begin
            if (cnt_reg >= pat_last(pat_reg)) begin
                // new state shows from the next whole repetition
                pat_reg <= pat_want; // [RULE_20]
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + MS_W'(1);
            end
        end
    end

    always_comb begin
        case (pat_reg)
            PAT_ON:     green_lvl = 1'b1; // [RULE_03]
            PAT_SINGLE: begin
                green_lvl = flash_hit(cnt_reg, `NSL_FLASH_SINGLE); // [RULE_17]
            end
            PAT_DOUBLE: begin
                green_lvl = flash_hit(cnt_reg, `NSL_FLASH_DOUBLE); // [RULE_01]
            end
            PAT_TRIPLE: begin
                green_lvl = flash_hit(cnt_reg, `NSL_FLASH_TRIPLE); // [RULE_02]
            end
            PAT_BLINK: begin
                green_lvl = cnt_reg < MS_W'(`NSL_BLINK_PER_MS / 2); // [RULE_04]
            end
            PAT_FLICKER: begin
                green_lvl = cnt_reg < MS_W'(`NSL_FLICK_PER_MS / 2); // [RULE_19]
            end
            default:    green_lvl = 1'b0;
        endcase
    end

    //////////////////////////////////////////////////////////////////////
    // red manager-failure indication, controlled node only

    always_comb begin
        red_fail = 1'b0;
        if (!mn_reg && MN_FAIL) begin
            case (state_reg)
                NS_PREOP1, NS_PREOP2, NS_READY: red_fail = 1'b1; // [RULE_07]
                default:                        red_fail = 1'b0;
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////
    // registered outputs

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            LED_GREEN <= 1'b0;
            LED_RED   <= 1'b0;
        end else if (err_reg) begin
            LED_GREEN <= 1'b0;     // [RULE_21]
            LED_RED   <= red_code; // [RULE_21] [RULE_13]
        end else begin
            LED_GREEN <= green_lvl;
            LED_RED   <= red_fail;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            NODE_STATE  <= NS_NOT_ACTIVE;
            CTL         <= '0;
            ERR_LATCHED <= 1'b0;
        end else begin
            NODE_STATE  <= state_reg;
            CTL         <= ctl_next;
            ERR_LATCHED <= err_reg;
        end
    end
endmodule

/* File: nsl_led_model.sv */
// Purpose: watcher for one LED
// Assumes: led is a registered level
// Notes:   last on/off run lengths, rise count
`timescale 1ns/1ps
module nsl_led_model (
    input  wire logic clk,     // sampling clock
    input  wire logic led,     // lamp drive, 1 lit
    output int        on_len,  // last on run, cycles
    output int        off_len, // last off run, cycles
    output int        rises    // rising edges seen
);
    logic prev = 1'b0;
    int   run  = 0;
    always @(posedge clk) begin
        prev <= led;
        if (led != prev) begin
            run <= 1;
            if (led) begin
                rises   <= rises + 1;
                off_len <= run;
            end else
                on_len <= run;
        end else
            run <= run + 1;
    end
endmodule

/* File: nsl_status_led_assertions.sv */
// Purpose: port checker of the LED sequencer
// Assumes: TICK_DIV cycles per millisecond
// Notes:   green timing judged by the bench
`timescale 1ns/1ps
`include "nsl_cfg.svh"
module nsl_status_led_chk #(
    parameter int unsigned TICK_DIV = 50000
) (
    input wire logic              CLOCK,       // clock
    input wire logic              RST_N,       // sync reset, low
    input wire nsl_pkg::nsl_evt_t EVT,         // events
    input wire logic              MN_FAIL,     // manager lost
    input wire nsl_pkg::nsl_err_t ERR,         // faults
    input wire nsl_pkg::nsl_node_t NODE_STATE, // state
    input wire nsl_pkg::nsl_ctl_t CTL,         // enables
    input wire logic              ERR_LATCHED, // error held
    input wire logic              LED_GREEN,   // status LED
    input wire logic              LED_RED      // error LED
);
    import nsl_pkg::*;
    // one ms slack for tick alignment
    localparam int RUN_MAX = (`NSL_ERR_LONG_MS + 1) * TICK_DIV;
    int red_run;
    always_ff @(posedge CLOCK) begin
        if (!RST_N || !LED_RED || !ERR_LATCHED)
            red_run <= 0;
        else
            red_run <= red_run + 1;
    end
////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    stop_ctl_a: assert property (
        NODE_STATE == NS_STOPPED |-> CTL == 8'h20)
        else $error("stopped data path on");
    oper_ctl_a: assert property (
        NODE_STATE == NS_OPER |-> CTL == 8'h77)
        else $error("oper enables wrong");
    ready_ctl_a: assert property (
        NODE_STATE == NS_READY |->
        CTL.cyclic_run && CTL.async_run && !CTL.eval_rx)
        else $error("ready enables wrong");
    preop2_ctl_a: assert property (
        NODE_STATE == NS_PREOP2 |->
        !CTL.eval_rx && CTL.cyclic_run == CTL.discard_pdo)
        else $error("pre-op 2 enables wrong");
    mn_nostop_a: assert property (
        CTL.discard_pdo |=> NODE_STATE != NS_STOPPED)
        else $error("manager entered stopped");
    stop_entry_a: assert property (
        $changed(NODE_STATE) && NODE_STATE == NS_STOPPED |->
        $past(EVT.cmd_stop, 1) || $past(EVT.cmd_stop, 2) ||
        $past(EVT.cmd_stop, 3))
        else $error("stopped without command");
    red_cause_a: assert property (
        LED_RED && !ERR_LATCHED |->
        NODE_STATE inside {NS_PREOP1, NS_PREOP2, NS_READY} &&
        (CTL.accept_cfg || CTL.pdo_mapped))
        else $error("red lit without cause");
    err_take_a: assert property (
        ERR != 2'h0 && !ERR_LATCHED |-> ##[1:3] ERR_LATCHED)
        else $error("fault not latched");
    err_hold_a: assert property (
        ERR_LATCHED |=> ERR_LATCHED)
        else $error("error latch dropped");
    err_blank_a: assert property (
        ERR_LATCHED |-> !LED_GREEN)
        else $error("green lit in error");
    red_phase_a: assert property (
        red_run <= RUN_MAX)
        else $error("red phase too long");
    err_seen_c: cover property ($rose(ERR_LATCHED));
    stop_seen_c: cover property (NODE_STATE == NS_STOPPED);
    red_fail_c: cover property (LED_RED && !ERR_LATCHED);
endmodule

bind nsl_status_led nsl_status_led_chk #(.TICK_DIV(TICK_DIV)) chk (
    .CLOCK(CLOCK), .RST_N(RST_N), .EVT(EVT), .MN_FAIL(MN_FAIL),
    .ERR(ERR), .NODE_STATE(NODE_STATE), .CTL(CTL),
    .ERR_LATCHED(ERR_LATCHED), .LED_GREEN(LED_GREEN),
    .LED_RED(LED_RED));

/* File: tb.sv */
// Purpose: bench for the LED sequencer
// Assumes: one ms is MS cycles
// Notes:   green judged by rises per period
`timescale 1ns/1ps
module tb;
    import nsl_pkg::*;
    localparam int MS = 2;
    localparam logic [6:0] E_TO = 7'h40, E_FR = 7'h20, E_SOC = 7'h10;
    localparam logic [6:0] E_RDY = 7'h08, E_OPR = 7'h04, E_STP = 7'h02,
        E_P2 = 7'h01;
    logic      CLOCK = 1'b0;
    logic      RST_N = 1'b0;
    logic      ROLE_MN = 1'b0;
    logic      MN_FAIL = 1'b0;
    nsl_evt_t  EVT = '0;
    nsl_err_t  ERR = '0;
    nsl_node_t NODE_STATE;
    nsl_ctl_t  CTL;
    logic      ERR_LATCHED, LED_GREEN, LED_RED;
    int        g_on, g_off, g_rise, r_on, r_off, r_rise;
    int        bad_count = 0, samples_checked = 0;
    always #10 CLOCK = ~CLOCK;
    nsl_status_led #(.TICK_DIV(MS)) uut (
        .CLOCK(CLOCK), .RST_N(RST_N), .ROLE_MN(ROLE_MN), .EVT(EVT),
        .MN_FAIL(MN_FAIL), .ERR(ERR), .NODE_STATE(NODE_STATE),
        .CTL(CTL), .ERR_LATCHED(ERR_LATCHED), .LED_GREEN(LED_GREEN),
        .LED_RED(LED_RED));
    nsl_led_model g_mod (.clk(CLOCK), .led(LED_GREEN), .on_len(g_on),
        .off_len(g_off), .rises(g_rise));
    nsl_led_model r_mod (.clk(CLOCK), .led(LED_RED), .on_len(r_on),
        .off_len(r_off), .rises(r_rise));
////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks=%0d bad=%0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    function automatic logic near(input int got, input int exp);
        return got >= exp - MS && got <= exp + MS;
    endfunction
    task automatic do_reset(input logic mn);
        RST_N = 1'b0;
        ROLE_MN = mn;
        MN_FAIL = 1'b0;
        repeat (20) @(negedge CLOCK);
        RST_N = 1'b1;
    endtask
    // pulse, then two edges for the answer
    task automatic step(input logic [6:0] e, input nsl_node_t s,
                        input logic [7:0] c);
        @(negedge CLOCK);
        EVT = nsl_evt_t'(e);
        @(negedge CLOCK);
        EVT = '0;
        repeat (2) @(negedge CLOCK);
        check(NODE_STATE, s);
        check(CTL, c);
    endtask
    // pattern swaps at a repetition, settle first
    task automatic green(input int settle, input int win, input int exp);
        int r0;
        repeat (settle * MS) @(negedge CLOCK);
        r0 = g_rise;
        repeat (win * MS) @(negedge CLOCK);
        check(g_rise - r0, exp);
    endtask
    task automatic wait_red(input logic lvl);
        int n;
        for (n = 0; n < 2500 * MS && LED_RED !== lvl; n++)
            @(negedge CLOCK);
        if (LED_RED !== lvl) begin
            bad_count++;
            end_of_test();
        end
        @(negedge CLOCK);
    endtask
////////////////////////////////////////////////////////////
    task automatic cn_walk;
        do_reset(1'b0);
        step(E_TO, NS_BASIC_ETH, 8'h00);
        green(200, 1000, 10);
        step(E_FR, NS_PREOP1, 8'h80);
        green(1100, 1000, 1);
        step(E_RDY, NS_PREOP1, 8'h80);
        step(E_SOC, NS_PREOP2, 8'h80);
        green(1100, 1000, 2);
        MN_FAIL = 1'b1;
        repeat (3) @(negedge CLOCK);
        check(LED_RED, 1'b1);
        step(E_RDY, NS_READY, 8'h66);
        check(LED_RED, 1'b1);
        MN_FAIL = 1'b0;
        green(1100, 1000, 3);
        check(LED_RED, 1'b0);
        step(E_OPR, NS_OPER, 8'h77);
        green(1100, 1000, 0);
        check(LED_GREEN, 1'b1);
        step(E_STP | E_OPR, NS_STOPPED, 8'h20);
        step(E_OPR, NS_STOPPED, 8'h20);
        green(1100, 2000, 5);
        step(E_P2, NS_PREOP2, 8'h80);
    endtask
    task automatic mn_walk;
        do_reset(1'b1);
        step(E_TO, NS_PREOP1, 8'h00);
        step(E_P2, NS_PREOP2, 8'h48);
        MN_FAIL = 1'b1;
        step(E_STP, NS_PREOP2, 8'h48);
        check(LED_RED, 1'b0);
        step(E_RDY, NS_READY, 8'h68);
        step(E_OPR, NS_OPER, 8'h77);
        step(E_STP, NS_OPER, 8'h77);
    endtask
    // first code skewed by tick alignment
    task automatic err_code(input logic [1:0] e, input logic [3:0] pat);
        int ph;
        do_reset(1'b0);
        step(E_TO, NS_BASIC_ETH, 8'h00);
        ERR = nsl_err_t'(e);
        @(negedge CLOCK);
        ERR = '0;
        repeat (2) @(negedge CLOCK);
        check(ERR_LATCHED, 1'b1);
        check(LED_GREEN, 1'b0);
        for (ph = 0; ph < 4; ph++) begin
            wait_red(1'b1);
            wait_red(1'b0);
        end
        wait_red(1'b1);
        check(near(r_off, 2000 * MS), 1'b1);
        for (ph = 3; ph >= 0; ph--) begin
            wait_red(1'b0);
            check(near(r_on, (pat[ph] ? 600 : 150) * MS), 1'b1);
            if (ph > 0) begin
                wait_red(1'b1);
                check(near(r_off, 150 * MS), 1'b1);
            end
        end
    endtask
    initial begin
        cn_walk();
        mn_walk();
        err_code(2'b10, 4'h1);
        err_code(2'b11, 4'h9);
        end_of_test();
    end
endmodule
